// >>> verilog/docr_output_config_registers.sv
`default_nettype none
// Notes on behaviour
// - Address byte 55h writes the control register from the frame data word.
// - Control bit 15 or the clear level pin picks clear level: code zero on every range, or midscale on unipolar ranges (bipolar stays at code zero).
// - Control bit 14 widens the voltage range by ten percent.
// - Control bit 13 selects the external current-setting resistor.
// - Control bit 12 enables outputs per range; clear means both high impedance.
// - Ramp rate bits 11:8 and step bits 7:5 are ignored unless ramping enabled.
// - Control bit 4 ramps output changes; clear means immediate update.
// - Address byte 57h writes the configuration register from the data word.
// - Current range bits 10:9 apply only in dual mode; no data clear.
// - Configuration bit 8 enables both outputs from one shared code.
// - Configuration bit 7 switches the sense node pulldown to ground.
// - Configuration bit 5 applies gain and zero trim to the code.
// - Configuration bit 4 connects modulation input, only in 4-20 mA range.
// - Configuration bit 3 enables frame error checking.
// - Output code register holds unsigned 16-bit code, reset zero.
// - Twelve-bit variant keeps bits 15:4; low four ignored, read zero.
// - Gain trim register holds unsigned 16-bit gain, reset zero.
// - Zero trim register holds signed 16-bit offset, reset zero.
// - Address bytes 58h and 59h write gain and zero trim registers.
// - A range change clears the output code to the selected clear level.
module docr_output_config_registers
   import docr_pkg::*;
#(
   parameter int CODE_BITS = 16
)(
   // Clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   // Decoded frame from the serial interface
   input  wire logic        frameValid,
   input  wire logic [7:0]  frameAddr,
   input  wire logic [15:0] frameData,
   input  wire logic        frameCheckOk,
   input  wire logic [15:0] statusWord,
   input  wire logic        clearLevelPin,
   // Readback and frame error
   output logic [15:0]      readData,
   output logic             readValid,
   output logic             frameError,
   // Control fields
   output logic             clearLevelSelect,
   output logic             overrangeExtend,
   output logic             externalResistorSelect,
   output logic             voltageOutputOn,
   output logic             currentOutputOn,
   output logic [2:0]       voltageRange,
   output logic [2:0]       currentRange,
   output logic             rampEnable,
   output logic [3:0]       rampClockRate,
   output logic [2:0]       rampStepSize,
   output logic             chainEnable,
   // Configuration fields
   output logic             sensePulldown,
   output logic             modulationInjectEnable,
   output logic             frameCheckEnable,
   output logic             timeoutEnable,
   output logic [1:0]       timeoutPeriod,
   // Converter code
   output logic [15:0]      outputCode
);
   import docr_pkg::*;

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   localparam logic [15:0] CODE_MASK = 16'hFFFF << (16 - CODE_BITS);

   function automatic docr_cmd_t decodeCmd(input logic [7:0] addr);
      if (addr == ADDR_READ) begin
         return DOCR_READ;
      end
      if (addr == ADDR_CONTROL || addr == ADDR_CONFIG || addr == ADDR_GAIN ||
          addr == ADDR_ZERO || addr == ADDR_DATA || addr == ADDR_SWRESET) begin
         return DOCR_WRITE;
      end
      return DOCR_OTHER;
   endfunction : decodeCmd

   logic [15:0] ctl_q;
   logic [15:0] cfg_q;
   logic [15:0] code_q;
   logic [15:0] gain_q;
   logic [15:0] zero_q;
   logic [15:0] clearCode;
   docr_cmd_t   cmd;
   logic        accept;
   logic        swReset;
   logic        ctlWrite;
   logic        rangeChange;

   // -------------------------------------------------------------------
   // Frame acceptance
   // -------------------------------------------------------------------
   assign cmd      = decodeCmd(frameAddr);
   // Without checking enabled every frame is taken as it arrives.
   assign accept   = frameValid && (frameCheckOk || !cfg_q[CFG_CHECK_BIT]);
   assign swReset  = accept && frameAddr == ADDR_SWRESET && frameData[0];
   assign ctlWrite = accept && frameAddr == ADDR_CONTROL;
   assign rangeChange = ctlWrite &&
                        frameData[CTL_RANGE_HI:CTL_RANGE_LO] != ctl_q[CTL_RANGE_HI:CTL_RANGE_LO];

   docr_clear_level u_clear (
      .clearSel  (clearLevelPin | frameData[CTL_CLEAR_LEVEL_SELECT_BIT]),
      .range     (frameData[CTL_RANGE_HI:CTL_RANGE_LO]),
      .clearCode (clearCode)
   );

   // -------------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctl_q <= RST_CONTROL;
      end else if (clkEn) begin
         if (swReset) begin
            ctl_q <= RST_CONTROL;
         end else if (ctlWrite) begin
            ctl_q <= frameData;
         end
      end
   end

   // -------------------------------------------------------------------
   // Configuration register
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_q <= RST_CONFIG;
      end else if (clkEn) begin
         if (swReset) begin
            cfg_q <= RST_CONFIG;
         end else if (accept && frameAddr == ADDR_CONFIG) begin
            // Reserved bits are kept at zero even if the host slips.
            cfg_q <= frameData & CFG_WRITABLE;
         end
      end
   end

   // -------------------------------------------------------------------
   // Output code and trim registers
   // -------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         code_q <= RST_CODE;
      end else if (clkEn) begin
         if (swReset) begin
            code_q <= RST_CODE;
         end else if (rangeChange) begin
            code_q <= clearCode & CODE_MASK;
         end else if (accept && frameAddr == ADDR_DATA) begin
            code_q <= frameData & CODE_MASK;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gain_q <= RST_GAIN;
         zero_q <= RST_ZERO;
      end else if (clkEn) begin
         if (swReset) begin
            gain_q <= RST_GAIN;
            zero_q <= RST_ZERO;
         end else if (accept && frameAddr == ADDR_GAIN) begin
            gain_q <= frameData & CODE_MASK;
         end else if (accept && frameAddr == ADDR_ZERO) begin
            zero_q <= frameData & CODE_MASK;
         end
      end
   end

   // -------------------------------------------------------------------
   // Trimmed code
   // -------------------------------------------------------------------
   // Gain is a fraction of full scale added on top of unity, so the zero
   // default leaves the code untouched; the sum saturates at both ends.
   logic [31:0]        gainProd;
   logic signed [18:0] trimSum;
   logic [15:0]        trimmed;
   always_comb begin
      gainProd = code_q * gain_q;
      trimSum  = $signed({3'h0, code_q}) + $signed({3'h0, gainProd[31:16]})
                 + $signed({{3{zero_q[15]}}, zero_q});
      if (trimSum < 0) begin
         trimmed = 16'h0000;
      end else if (trimSum > 19'sh0FFFF) begin
         trimmed = 16'hFFFF;
      end else begin
         trimmed = trimSum[15:0];
      end
   end

   // -------------------------------------------------------------------
   // Field outputs, all registered
   // -------------------------------------------------------------------
   logic dual;
   logic on;
   assign dual = cfg_q[CFG_DUAL_BIT];
   assign on   = ctl_q[CTL_ON_BIT];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         clearLevelSelect       <= 1'b0;
         overrangeExtend        <= 1'b0;
         externalResistorSelect <= 1'b0;
         voltageOutputOn        <= 1'b0;
         currentOutputOn        <= 1'b0;
         voltageRange           <= 3'h0;
         currentRange           <= 3'h0;
         rampEnable             <= 1'b0;
         rampClockRate          <= 4'h0;
         rampStepSize           <= 3'h0;
         chainEnable            <= 1'b0;
      end else if (clkEn) begin
         clearLevelSelect       <= ctl_q[CTL_CLEAR_LEVEL_SELECT_BIT] | clearLevelPin;
         overrangeExtend        <= ctl_q[CTL_OVR_BIT];
         externalResistorSelect <= ctl_q[CTL_EXTERNAL_RESISTOR_SELECT_BIT];
         voltageRange           <= ctl_q[CTL_RANGE_HI:CTL_RANGE_LO];
         // Outside dual mode the range picks voltage (top bit low) or current.
         voltageOutputOn        <= on && (dual || !ctl_q[CTL_RANGE_HI]);
         currentOutputOn        <= on && (dual || ctl_q[CTL_RANGE_HI]);
         currentRange           <= dual ? {1'b1, cfg_q[CFG_IRANGE_HI:CFG_IRANGE_LO]}
                                        : ctl_q[CTL_RANGE_HI:CTL_RANGE_LO];
         rampEnable             <= ctl_q[CTL_RAMP_BIT];
         rampClockRate          <= ctl_q[CTL_RAMP_BIT] ? ctl_q[CTL_RCLK_HI:CTL_RCLK_LO] : 4'h0;
         rampStepSize           <= ctl_q[CTL_RAMP_BIT] ? ctl_q[CTL_RSTEP_HI:CTL_RSTEP_LO] : 3'h0;
         chainEnable            <= ctl_q[CTL_CHAIN_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sensePulldown          <= 1'b0;
         modulationInjectEnable <= 1'b0;
         frameCheckEnable       <= 1'b0;
         timeoutEnable          <= 1'b0;
         timeoutPeriod          <= 2'h0;
         outputCode             <= 16'h0000;
      end else if (clkEn) begin
         sensePulldown          <= cfg_q[CFG_PULLDN_BIT];
         // The injection path is only meaningful on the 4-20 mA range.
         modulationInjectEnable <= cfg_q[CFG_MOD_BIT] && currentRange == RANGE_I4_20;
         frameCheckEnable       <= cfg_q[CFG_CHECK_BIT];
         timeoutEnable          <= cfg_q[CFG_WDOG_BIT];
         timeoutPeriod          <= cfg_q[CFG_TIMEOUT_PERIOD_HI:CFG_TIMEOUT_PERIOD_LO];
         outputCode             <= (cfg_q[CFG_TRIM_BIT] ? trimmed : code_q) & CODE_MASK;
      end
   end

   // -------------------------------------------------------------------
   // Readback and frame error
   // -------------------------------------------------------------------
   logic [15:0] rdMux;
   always_comb begin
      case (frameData[5:0])
         RD_CONFIG: rdMux = cfg_q;
         RD_GAIN:   rdMux = gain_q;
         RD_ZERO:   rdMux = zero_q;
         default: begin
            case (frameData[1:0])
               RD_STATUS_LO:  rdMux = statusWord;
               RD_DATA_LO:    rdMux = code_q;
               RD_CONTROL_LO: rdMux = ctl_q;
               default:       rdMux = 16'h0000;
            endcase
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         readData   <= 16'h0000;
         readValid  <= 1'b0;
         frameError <= 1'b0;
      end else if (clkEn) begin
         readValid  <= accept && cmd == DOCR_READ;
         frameError <= frameValid && !accept;
         if (accept && cmd == DOCR_READ) begin
            readData <= rdMux;
         end
      end
   end
endmodule : docr_output_config_registers
`default_nettype wire

// >>> verilog/docr_pkg.sv
`default_nettype none
package docr_pkg;
   // -------------------------------------------------------------------
   // Frame address bytes
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_NOP      = 8'h00;
   localparam logic [7:0] ADDR_READ     = 8'h02;
   localparam logic [7:0] ADDR_CONTROL  = 8'h55;
   localparam logic [7:0] ADDR_SWRESET  = 8'h56;
   localparam logic [7:0] ADDR_CONFIG   = 8'h57;
   localparam logic [7:0] ADDR_GAIN     = 8'h58;
   localparam logic [7:0] ADDR_ZERO     = 8'h59;
   localparam logic [7:0] ADDR_DATA     = 8'h01;

   // -------------------------------------------------------------------
   // Read select codes (low six bits of the read word; the _LO codes match the low two bits)
   // -------------------------------------------------------------------
   localparam logic [5:0] RD_CONFIG     = 6'h0B;
   localparam logic [5:0] RD_GAIN       = 6'h13;
   localparam logic [5:0] RD_ZERO       = 6'h17;
   localparam logic [1:0] RD_STATUS_LO  = 2'h0;
   localparam logic [1:0] RD_DATA_LO    = 2'h1;
   localparam logic [1:0] RD_CONTROL_LO = 2'h2;

   // -------------------------------------------------------------------
   // Control field positions
   // -------------------------------------------------------------------
   localparam int CTL_CLEAR_LEVEL_SELECT_BIT  = 15;
   localparam int CTL_OVR_BIT     = 14;
   localparam int CTL_EXTERNAL_RESISTOR_SELECT_BIT    = 13;
   localparam int CTL_ON_BIT      = 12;
   localparam int CTL_RCLK_HI     = 11;
   localparam int CTL_RCLK_LO     = 8;
   localparam int CTL_RSTEP_HI    = 7;
   localparam int CTL_RSTEP_LO    = 5;
   localparam int CTL_RAMP_BIT    = 4;
   localparam int CTL_CHAIN_BIT   = 3;
   localparam int CTL_RANGE_HI    = 2;
   localparam int CTL_RANGE_LO    = 0;

   // -------------------------------------------------------------------
   // Configuration field positions
   // -------------------------------------------------------------------
   localparam int CFG_IRANGE_HI   = 10;
   localparam int CFG_IRANGE_LO   = 9;
   localparam int CFG_DUAL_BIT    = 8;
   localparam int CFG_PULLDN_BIT  = 7;
   localparam int CFG_TRIM_BIT    = 5;
   localparam int CFG_MOD_BIT     = 4;
   localparam int CFG_CHECK_BIT   = 3;
   localparam int CFG_WDOG_BIT    = 2;
   localparam int CFG_TIMEOUT_PERIOD_HI     = 1;
   localparam int CFG_TIMEOUT_PERIOD_LO     = 0;
   localparam logic [15:0] CFG_WRITABLE = 16'h07BF;

   // -------------------------------------------------------------------
   // Reset values and range codes
   // -------------------------------------------------------------------
   localparam logic [15:0] RST_CONTROL = 16'h0000;
   localparam logic [15:0] RST_CONFIG  = 16'h0000;
   localparam logic [15:0] RST_CODE    = 16'h0000;
   localparam logic [15:0] RST_GAIN    = 16'h0000;
   localparam logic [15:0] RST_ZERO    = 16'h0000;
   localparam logic [2:0]  RANGE_I4_20 = 3'h5;
   localparam logic [15:0] CODE_MID    = 16'h8000;

   typedef enum logic [1:0] {DOCR_WRITE, DOCR_READ, DOCR_OTHER} docr_cmd_t;
endpackage : docr_pkg
`default_nettype wire

// >>> verilog/docr_clear_level.sv
`default_nettype none
// -------------------------------------------------------------------
// Clear code for a range and clear select
// -------------------------------------------------------------------
module docr_clear_level
   import docr_pkg::*;
(
   // Selection
   input  wire logic        clearSel,
   input  wire logic [2:0]  range,
   // Result
   output logic [15:0]      clearCode
);
   // Ranges 3 and 4 are the bipolar ranges; negative full scale is
   // code zero, so only a unipolar range with the select set lands at mid.
   logic bipolar;
   assign bipolar   = (range == 3'h3) || (range == 3'h4);
   assign clearCode = (clearSel && !bipolar) ? CODE_MID : RST_CODE;
endmodule : docr_clear_level
`default_nettype wire

// >>> verification/docr_host_model.sv
`default_nettype none
module docr_host_model
   import docr_pkg::*;
(
   // Clock
   input  wire logic        core_clk,
   // Frame toward the register bank
   output var  logic        frameValid,
   output var  logic [7:0]  frameAddr,
   output var  logic [15:0] frameData,
   output var  logic        frameCheckOk
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      frameValid   = 1'b0;
      frameAddr    = ADDR_NOP;
      frameData    = 16'h0000;
      frameCheckOk = 1'b0;
   end

   // One frame for one cycle, then an idle cycle. Released lines show the inverse
   // of their last value, so stale data can never pass for a live frame.
   task automatic send(input logic [7:0] addr, input logic [15:0] data, input logic checkOk);
      @(negedge core_clk);
      frameValid   = 1'b1;
      frameAddr    = addr;
      frameData    = (addr == ADDR_CONFIG) ? (data & 16'h07BF) : data;
      frameCheckOk = checkOk;
      @(negedge core_clk);
      frameValid   = 1'b0;
      frameAddr    = ~addr;
      frameData    = ~frameData;
      frameCheckOk = ~checkOk;
   endtask : send
endmodule : docr_host_model
`default_nettype wire

// >>> verification/docr_output_config_registers_asserts.sv
`default_nettype none
module docr_output_config_registers_asserts
   import docr_pkg::*;
(
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // Frame side
   input wire logic        clkEn,
   input wire logic        frameValid,
   input wire logic [7:0]  frameAddr,
   input wire logic [15:0] frameData,
   input wire logic        frameCheckOk,
   input wire logic        frameError,
   // Field outputs
   input wire logic        overrangeExtend,
   input wire logic        externalResistorSelect,
   input wire logic        voltageOutputOn,
   input wire logic        currentOutputOn,
   input wire logic [2:0]  currentRange,
   input wire logic        rampEnable,
   input wire logic [3:0]  rampClockRate,
   input wire logic [2:0]  rampStepSize,
   input wire logic        chainEnable,
   input wire logic        sensePulldown,
   input wire logic        modulationInjectEnable,
   input wire logic        frameCheckEnable,
   input wire logic        timeoutEnable,
   input wire logic [1:0]  timeoutPeriod
);
   timeunit 1ns;
   timeprecision 1ns;

   // Frames come at least two cycles apart, so the registered check enable
   // already reflects the setting that governs each frame.
   wire logic accepted = frameValid && clkEn && (frameCheckOk || !frameCheckEnable);
   wire logic refused  = frameValid && clkEn && frameCheckEnable && !frameCheckOk;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_ctrl_bits: assert property (
      accepted && frameAddr == ADDR_CONTROL |=> ##1 overrangeExtend == $past(frameData[14], 2)
      && externalResistorSelect == $past(frameData[13], 2) && chainEnable == $past(frameData[3], 2))
      else $error("control bits not taken from the frame");
   a_ramp_gate: assert property (
      !rampEnable |-> rampClockRate == 4'h0 && rampStepSize == 3'h0)
      else $error("ramp fields visible while ramping is off");
   a_out_off: assert property (
      accepted && frameAddr == ADDR_CONTROL && !frameData[12] |=> ##1 !voltageOutputOn && !currentOutputOn)
      else $error("an output stayed on with outputs disabled");
   a_dual_range: assert property (
      accepted && frameAddr == ADDR_CONFIG && frameData[8] |=> ##1 currentRange == {1'b1, $past(frameData[10:9], 2)})
      else $error("dual mode current range wrong");
   a_cfg_bits: assert property (
      accepted && frameAddr == ADDR_CONFIG |=> ##1 sensePulldown == $past(frameData[7], 2)
      && frameCheckEnable == $past(frameData[3], 2) && timeoutEnable == $past(frameData[2], 2)
      && timeoutPeriod == $past(frameData[1:0], 2))
      else $error("configuration bits not taken from the frame");
   a_mod_range: assert property (
      modulationInjectEnable |-> $past(currentRange) == RANGE_I4_20)
      else $error("modulation injected outside the 4-20 mA range");
   a_bad_flag: assert property (
      refused |=> frameError)
      else $error("failed frame not flagged");
   a_bad_keep: assert property (
      refused && frameAddr == ADDR_CONTROL |=> ##1 $stable(overrangeExtend) && $stable(chainEnable))
      else $error("failed frame changed the control fields");
endmodule : docr_output_config_registers_asserts

bind docr_output_config_registers docr_output_config_registers_asserts docr_output_config_registers_asserts_i (
   .core_clk, .rst_n, .clkEn, .frameValid, .frameAddr, .frameData, .frameCheckOk, .frameError,
   .overrangeExtend, .externalResistorSelect, .voltageOutputOn, .currentOutputOn, .currentRange,
   .rampEnable, .rampClockRate, .rampStepSize, .chainEnable, .sensePulldown, .modulationInjectEnable,
   .frameCheckEnable, .timeoutEnable, .timeoutPeriod);
`default_nettype wire

// >>> verification/docr_output_config_registers_test.sv
`default_nettype none
module docr_output_config_registers_test
   import docr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic        core_clk, rst_n, clkEn, clearLevelPin, frameValid, frameCheckOk, readValid, frameError;
   logic        clearLevelSelect, overrangeExtend, externalResistorSelect, voltageOutputOn, currentOutputOn;
   logic        rampEnable, chainEnable, sensePulldown, modulationInjectEnable, frameCheckEnable, timeoutEnable;
   logic [7:0]  frameAddr;
   logic [15:0] frameData, statusWord, readData, outputCode;
   logic [2:0]  voltageRange, currentRange, rampStepSize;
   logic [3:0]  rampClockRate;
   logic [1:0]  timeoutPeriod;
   int          err_count = 0;
   int          samples_checked = 0;
   logic [5:0]  rstSel [5] = '{6'h02, 6'h0B, 6'h01, 6'h13, 6'h17};
   logic [15:0] rcCtl [5] = '{16'h1005, 16'h9001, 16'h9003, 16'h1003, 16'h1001};
   logic [15:0] rcExp [5] = '{16'h0000, 16'h8000, 16'h0000, 16'h1234, 16'h8000};
   // Field outputs packed in the control layout, bit 12 showing the voltage enable.
   wire logic [15:0] ctlView = {clearLevelSelect, overrangeExtend, externalResistorSelect, voltageOutputOn,
                                rampClockRate, rampStepSize, rampEnable, chainEnable, voltageRange};
   wire logic [15:0] cfgView = {5'h00, voltageOutputOn, currentOutputOn, currentRange, sensePulldown,
                                modulationInjectEnable, frameCheckEnable, timeoutEnable, timeoutPeriod};

   docr_output_config_registers docr_output_config_registers_i (
      .core_clk, .rst_n, .clkEn, .frameValid, .frameAddr, .frameData, .frameCheckOk, .statusWord,
      .clearLevelPin, .readData, .readValid, .frameError, .clearLevelSelect, .overrangeExtend,
      .externalResistorSelect, .voltageOutputOn, .currentOutputOn, .voltageRange, .currentRange,
      .rampEnable, .rampClockRate, .rampStepSize, .chainEnable, .sensePulldown,
      .modulationInjectEnable, .frameCheckEnable, .timeoutEnable, .timeoutPeriod, .outputCode);
   docr_host_model docr_host_model_i (.core_clk, .frameValid, .frameAddr, .frameData, .frameCheckOk);

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Field outputs settle two edges after the frame; the extra wait covers the
   // modulation enable, which trails the current range by one more cycle.
   task automatic wr(input logic [7:0] addr, input logic [15:0] data);
      docr_host_model_i.send(addr, data, 1'b1);
      repeat (2) @(negedge core_clk);
   endtask : wr

   task automatic rd(input logic [5:0] sel, input logic [15:0] exp);
      int n;
      docr_host_model_i.send(ADDR_READ, {10'h000, sel}, 1'b1);
      for (n = 0; n < 3 && readValid !== 1'b1; n++) begin
         @(negedge core_clk);
      end
      if (readValid !== 1'b1) begin
         err_count++;
         tally_and_finish();
      end
      check("readData", readData, exp);
   endtask : rd

   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      tally_and_finish();
   end

   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      clearLevelPin = 1'b0;
      statusWord = 16'hA5C3;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      foreach (rstSel[i]) rd(rstSel[i], 16'h0000);
      check("ctlView", ctlView, 16'h0000);
      rd(6'h00, 16'hA5C3);
      wr(ADDR_CONTROL, 16'hFFF8);
      check("ctlView", ctlView, 16'hFFF8);
      rd(6'h02, 16'hFFF8);
      wr(ADDR_CONTROL, 16'h1FE0);
      check("ctlView", ctlView, 16'h1000);
      for (int i = 0; i < 5; i++) begin
         clearLevelPin = (i == 4);
         wr(ADDR_DATA, 16'h1234);
         check("outputCode", outputCode, 16'h1234);
         wr(ADDR_CONTROL, rcCtl[i]);
         check("outputCode", outputCode, rcExp[i]);
      end
      clearLevelPin = 1'b0;
      wr(ADDR_CONTROL, 16'h0005);
      check("outputsOn", {14'h0000, voltageOutputOn, currentOutputOn}, 16'h0000);
      wr(ADDR_CONTROL, 16'h1005);
      check("outputsOn", {14'h0000, voltageOutputOn, currentOutputOn}, 16'h0001);
      wr(ADDR_DATA, 16'h1234);
      wr(ADDR_CONFIG, 16'hFFFF);
      check("cfgView", cfgView, 16'h07EF);
      check("outputCode", outputCode, 16'h1234);
      rd(6'h0B, 16'h07BF);
      wr(ADDR_CONFIG, 16'h0338);
      check("cfgView", cfgView, 16'h0758);
      wr(ADDR_GAIN, 16'h8000);
      wr(ADDR_ZERO, 16'hFFF0);
      wr(ADDR_DATA, 16'h1000);
      check("outputCode", outputCode, 16'h17F0);
      rd(6'h13, 16'h8000);
      rd(6'h17, 16'hFFF0);
      // The error flag stands for one cycle only, right after the refused frame.
      docr_host_model_i.send(ADDR_CONTROL, 16'h0000, 1'b0);
      check("frameError", {15'h0000, frameError}, 16'h0001);
      repeat (2) @(negedge core_clk);
      check("ctlView", ctlView, 16'h1005);
      wr(ADDR_SWRESET, 16'h0001);
      check("ctlView", ctlView, 16'h0000);
      check("cfgView", cfgView, 16'h0000);
      check("outputCode", outputCode, 16'h0000);
      rd(6'h13, 16'h0000);
      tally_and_finish();
   end
endmodule : docr_output_config_registers_test
`default_nettype wire
